// *** core/serial_fifo_status.sv ***
`timescale 1ns/10ps
`include "sfifo_map.svh"
module serial_fifo_status #(
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic rx_byte_valid_i,
    input wire logic [8:0] rx_byte_i,
    input wire logic tx_frame_done_i,
    output logic [8:0] tx_byte_o,
    output logic tx_byte_valid_o,
    input wire logic channel_run_enable_i,
    input wire logic idle_mode_i,
    input wire logic idle_run_enable_i,
    input wire logic dma_busy_i,
    output logic rx_dma_req_o,
    output logic tx_dma_req_o,
    output logic irq_o
);
    sfifo_pkg::bus_req_type req;
    sfifo_pkg::dma_en_type dma_en_reg;
    sfifo_pkg::dma_state_type dma_state_reg;
    logic rx_overflow_flag_reg;
    logic tx_starved_flag_reg;
    logic [7:0] tx_fifo_control_reg;
    logic fifo_use_enable_reg;
    logic [3:0] irq_status_reg;
    logic [3:0] irq_mask_reg;
    logic [3:0] irq_event;
    logic [2:0] rx_fill_level;
    logic [2:0] tx_fill_level;
    logic [8:0] rx_head;
    logic [8:0] tx_head;
    logic rx_pop;
    logic tx_push;
    logic tx_pop;
    logic tx_clear;
    logic rx_full_hit;
    logic tx_ctrl_reset;
    logic receive_interrupt;
    logic transmit_interrupt;
    logic receive_interrupt_q;
    logic transmit_interrupt_q;
    logic rx_req_next;
    logic tx_req_next;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    assign rx_pop = req.rd && hit(req.addr, `ADDR_DATA_BUF);
    assign tx_push = req.wr && hit(req.addr, `ADDR_DATA_BUF);
    assign tx_clear = req.wr && hit(req.addr, `ADDR_TX_CTRL) && req.wdata[`TX_CLEAR_BIT];
    assign rx_full_hit = rx_byte_valid_i && (rx_fill_level == 3'(DEPTH)) && !rx_pop;
    // a frame pulls the next byte; popping an empty fifo is a no-op
    assign tx_pop = tx_frame_done_i;
    assign tx_ctrl_reset = !channel_run_enable_i || (idle_mode_i && !idle_run_enable_i);

    byte_fifo #(.DEPTH(DEPTH)) rx_fifo (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .clear_i(1'b0),
        .push_i(rx_byte_valid_i),
        .push_data_i(rx_byte_i),
        .pop_i(rx_pop),
        .head_o(rx_head),
        .level_o(rx_fill_level)
    );

    byte_fifo #(.DEPTH(DEPTH)) tx_fifo (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .clear_i(tx_clear),
        .push_i(tx_push),
        .push_data_i(req.wdata[8:0]),
        .pop_i(tx_pop),
        .head_o(tx_head),
        .level_o(tx_fill_level)
    );

    // overflow: a clearing read in the same cycle blocks the set (rx_full_hit excludes rx_pop)
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rx_overflow_flag_reg <= 1'b0;
        end
        else if (rx_full_hit)
        begin
            rx_overflow_flag_reg <= 1'b1;
        end
        else if (rx_pop)
        begin
            rx_overflow_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            tx_starved_flag_reg <= `TX_STARVED_RESET;
        end
        else if (tx_frame_done_i && tx_fill_level == 3'h0)
        begin
            // set wins over a clearing push in the same cycle
            tx_starved_flag_reg <= 1'b1;
        end
        else if (tx_push)
        begin
            tx_starved_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i || tx_ctrl_reset)
        begin
            tx_fifo_control_reg <= 8'h00;
        end
        else if (req.wr && hit(req.addr, `ADDR_TX_CTRL))
        begin
            // clear bit is write-only, never stored
            tx_fifo_control_reg <= {1'b0, req.wdata[6:0]};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            dma_en_reg <= '0;
            fifo_use_enable_reg <= 1'b0;
            irq_mask_reg <= 4'h0;
        end
        else if (req.wr)
        begin
            if (hit(req.addr, `ADDR_DMA_EN))
            begin
                dma_en_reg.rx_dma_enable <= req.wdata[`RX_DMA_BIT];
                dma_en_reg.tx_dma_enable <= req.wdata[`TX_DMA_BIT];
            end
            if (hit(req.addr, `ADDR_CFG))
            begin
                fifo_use_enable_reg <= req.wdata[0];
            end
            if (hit(req.addr, `ADDR_IRQ_MASK))
            begin
                irq_mask_reg <= req.wdata[3:0];
            end
        end
    end

    // level conditions, only their rising edges set irq status: receive has data, transmit has space
    assign receive_interrupt = rx_fill_level != 3'h0;
    assign transmit_interrupt = tx_fill_level < 3'(DEPTH);
    assign irq_event = {transmit_interrupt && !transmit_interrupt_q,
                        receive_interrupt && !receive_interrupt_q,
                        tx_frame_done_i && tx_fill_level == 3'h0, rx_full_hit};

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            irq_status_reg <= 4'h0;
            receive_interrupt_q <= 1'b0;
            // empty tx fifo means space: idle level 1 avoids a false edge after reset
            transmit_interrupt_q <= 1'b1;
        end
        else
        begin
            receive_interrupt_q <= receive_interrupt;
            transmit_interrupt_q <= transmit_interrupt;
            // set wins over write-one-to-clear
            if (req.wr && hit(req.addr, `ADDR_IRQ_STATUS))
            begin
                irq_status_reg <= (irq_status_reg & ~req.wdata[3:0]) | irq_event;
            end
            else
            begin
                irq_status_reg <= irq_status_reg | irq_event;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // dma requests are edge-born pulses; a busy controller just loses them
    assign rx_req_next = dma_en_reg.rx_dma_enable && receive_interrupt
                         && !receive_interrupt_q;
    assign tx_req_next = dma_en_reg.tx_dma_enable && transmit_interrupt
                         && !transmit_interrupt_q;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            dma_state_reg <= sfifo_pkg::DMA_IDLE;
            rx_dma_req_o <= 1'b0;
            tx_dma_req_o <= 1'b0;
        end
        else
        begin
            rx_dma_req_o <= 1'b0;
            tx_dma_req_o <= 1'b0;
            unique case (dma_state_reg)
                sfifo_pkg::DMA_IDLE:
                begin
                    if (!dma_busy_i)
                    begin
                        rx_dma_req_o <= rx_req_next;
                        tx_dma_req_o <= tx_req_next;
                    end
                    if (dma_busy_i)
                    begin
                        dma_state_reg <= sfifo_pkg::DMA_BUSY;
                    end
                end
                sfifo_pkg::DMA_BUSY:
                begin
                    // requests arising here are dropped
                    if (!dma_busy_i)
                    begin
                        dma_state_reg <= sfifo_pkg::DMA_IDLE;
                    end
                end
                default:
                begin
                    dma_state_reg <= sfifo_pkg::DMA_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            tx_byte_o <= 9'h000;
            tx_byte_valid_o <= 1'b0;
        end
        else
        begin
            tx_byte_o <= tx_head;
            tx_byte_valid_o <= tx_fill_level != 3'h0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rdata_o <= 32'h0000_0000;
        end
        else if (req.rd)
        begin
            rdata_o <= 32'h0000_0000;
            unique case (req.addr)
                `ADDR_DATA_BUF: rdata_o <= {23'h0, rx_head};
                `ADDR_RX_STATUS: rdata_o <= {24'h0, rx_overflow_flag_reg, 4'h0, rx_fill_level};
                `ADDR_TX_STATUS: rdata_o <= {24'h0, tx_starved_flag_reg, 4'h0, tx_fill_level};
                `ADDR_DMA_EN: rdata_o <= {30'h0, dma_en_reg.rx_dma_enable, dma_en_reg.tx_dma_enable};
                `ADDR_TX_CTRL: rdata_o <= {24'h0, tx_fifo_control_reg};
                `ADDR_CFG: rdata_o <= {31'h0, fifo_use_enable_reg};
                `ADDR_IRQ_STATUS: rdata_o <= {28'h0, irq_status_reg};
                `ADDR_IRQ_MASK: rdata_o <= {28'h0, irq_mask_reg};
                default: rdata_o <= 32'h0000_0000;
            endcase
        end
    end

    a_ovf_set: assert property (@(posedge clk_i) disable iff (srst_i)
        rx_full_hit |=> rx_overflow_flag_reg) else $error("overflow not set");
    a_ovf_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        rx_pop && !rx_full_hit |=> !rx_overflow_flag_reg) else $error("overflow not cleared");
    a_starve_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        tx_push && !tx_frame_done_i |=> !tx_starved_flag_reg) else $error("starve not cleared");
    a_starve_set: assert property (@(posedge clk_i) disable iff (srst_i)
        tx_frame_done_i && tx_fill_level == 3'h0 |=> tx_starved_flag_reg)
        else $error("starve not set");
    a_tx_clear_level: assert property (@(posedge clk_i) disable iff (srst_i)
        tx_clear |=> tx_fill_level == 3'h0) else $error("tx clear failed");
    a_rx_level_max: assert property (@(posedge clk_i) disable iff (srst_i)
        rx_fill_level <= 3'(DEPTH)) else $error("rx level too big");
    a_dma_rx_gate: assert property (@(posedge clk_i) disable iff (srst_i)
        rx_dma_req_o |-> $past(dma_en_reg.rx_dma_enable)) else $error("rx dma ungated");
    a_dma_busy_drop: assert property (@(posedge clk_i) disable iff (srst_i)
        $past(dma_busy_i) |-> !rx_dma_req_o && !tx_dma_req_o) else $error("dma req while busy");
    a_ctrl_reset: assert property (@(posedge clk_i) disable iff (srst_i)
        tx_ctrl_reset |=> tx_fifo_control_reg == 8'h00) else $error("ctrl not reset");
    c_overflow: cover property (@(posedge clk_i) rx_full_hit);
    c_rx_dma: cover property (@(posedge clk_i) rx_dma_req_o);
    c_tx_dma: cover property (@(posedge clk_i) tx_dma_req_o);
    c_tx_full: cover property (@(posedge clk_i) tx_fill_level == 3'(DEPTH));
endmodule

// *** common/sfifo_map.svh ***
`ifndef SFIFO_MAP_SVH
`define SFIFO_MAP_SVH
`define ADDR_DATA_BUF 8'h00
`define ADDR_RX_STATUS 8'h04
`define ADDR_TX_STATUS 8'h08
`define ADDR_DMA_EN 8'h0C
`define ADDR_TX_CTRL 8'h10
`define ADDR_CFG 8'h14
`define ADDR_IRQ_STATUS 8'h18
`define ADDR_IRQ_MASK 8'h1C
`define FLAG_BIT 7
`define TX_CLEAR_BIT 7
`define RX_DMA_BIT 1
`define TX_DMA_BIT 0
`define TX_STARVED_RESET 1'b1
`define FIFO_DEPTH 4
`define IRQ_RX_OVERFLOW 0
`define IRQ_TX_STARVED 1
`define IRQ_RX_DATA 2
`define IRQ_TX_SPACE 3
`endif

// *** common/sfifo_pkg.sv ***
package sfifo_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;
    typedef struct packed {
        logic rx_dma_enable;
        logic tx_dma_enable;
    } dma_en_type;
    typedef enum logic [1:0] {DMA_IDLE, DMA_BUSY} dma_state_type;
endpackage

// *** core/byte_fifo.sv ***
`timescale 1ns/10ps
`include "sfifo_map.svh"
module byte_fifo #(
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic clear_i,
    input wire logic push_i,
    input wire logic [8:0] push_data_i,
    input wire logic pop_i,
    output logic [8:0] head_o,
    output logic [2:0] level_o
);
    logic [8:0] mem_reg [DEPTH];
    logic [1:0] wr_ptr_reg;
    logic [1:0] rd_ptr_reg;
    logic do_push;
    logic do_pop;
    // push into a full fifo is dropped unless a pop frees a slot in the same cycle
    assign do_push = push_i && ((level_o < 3'(DEPTH)) || do_pop);
    assign do_pop = pop_i && (level_o != 3'h0);
    assign head_o = mem_reg[rd_ptr_reg];
    always_ff @(posedge clk_i)
    begin
        if (do_push)
        begin
            mem_reg[wr_ptr_reg] <= push_data_i;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (srst_i || clear_i)
        begin
            wr_ptr_reg <= 2'h0;
            rd_ptr_reg <= 2'h0;
            level_o <= 3'h0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr_reg <= wr_ptr_reg + 2'h1;
            end
            if (do_pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 2'h1;
            end
            level_o <= level_o + 3'(do_push) - 3'(do_pop);
        end
    end
endmodule

// *** bench/dma_ctrl_model.sv ***
`timescale 1ns/10ps
module dma_ctrl_model (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic rx_req_i,
    input wire logic tx_req_i,
    input wire logic [3:0] hold_i,
    output logic busy_o
);
    logic [3:0] left_reg;
    // a request seen while a transfer runs is simply lost, like the real controller
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            left_reg <= 4'h0;
        else if ((rx_req_i || tx_req_i) && left_reg == 4'h0)
            left_reg <= hold_i;
        else if (left_reg != 4'h0)
            left_reg <= left_reg - 4'h1;
    end
    assign busy_o = (left_reg != 4'h0);
endmodule

// *** bench/serial_fifo_status_dma_request_bench.sv ***
`timescale 1ns/10ps
`include "sfifo_map.svh"
module serial_fifo_status_dma_request_bench;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic rx_byte_valid_i = 1'b0;
    logic [8:0] rx_byte_i = 9'h000;
    logic tx_frame_done_i = 1'b0;
    logic [8:0] tx_byte_o;
    logic tx_byte_valid_o;
    logic channel_run_enable_i = 1'b1;
    logic idle_mode_i = 1'b0;
    logic idle_run_enable_i = 1'b0;
    logic dma_busy_i;
    logic rx_dma_req_o;
    logic tx_dma_req_o;
    logic irq_o;
    logic irq_a;
    logic [3:0] dma_hold = 4'h0;
    logic [8:0] q [$];
    int errors = 0;
    int compares = 0;
    int rx_reqs = 0;
    int tx_reqs = 0;

    serial_fifo_status i_dut (.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .rx_byte_valid_i, .rx_byte_i, .tx_frame_done_i, .tx_byte_o, .tx_byte_valid_o,
        .channel_run_enable_i, .idle_mode_i, .idle_run_enable_i, .dma_busy_i,
        .rx_dma_req_o, .tx_dma_req_o, .irq_o);
    dma_ctrl_model i_dma (.clk_i, .srst_i, .rx_req_i(rx_dma_req_o), .tx_req_i(tx_dma_req_o),
        .hold_i(dma_hold), .busy_o(dma_busy_i));

    always #5 clk_i = ~clk_i;

    always @(posedge clk_i)
    begin
        if (rx_dma_req_o === 1'b1)
            rx_reqs <= rx_reqs + 1;
        if (tx_dma_req_o === 1'b1)
            tx_reqs <= tx_reqs + 1;
    end

    function automatic logic [31:0] stat(input logic flag, input int lvl);
        return {24'h00_0000, flag, 4'h0, 3'(lvl)};
    endfunction

    task automatic conclude();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, e);
    endtask

    task automatic pulse_in(input logic rx, input logic [8:0] d);
        @(posedge clk_i);
        rx_byte_valid_i <= rx;
        tx_frame_done_i <= !rx;
        rx_byte_i <= d;
        @(posedge clk_i);
        rx_byte_valid_i <= 1'b0;
        tx_frame_done_i <= 1'b0;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_i);
        errors++;
        conclude();
    end

    initial
    begin
        void'($urandom(32'h39ef));
        repeat (12) @(posedge clk_i);
        srst_i <= 1'b0;
        expect_reg(`ADDR_RX_STATUS, stat(1'b0, 0));
        expect_reg(`ADDR_TX_STATUS, stat(1'b1, 0));
        expect_reg(`ADDR_DMA_EN, 32'h0000_0000);
        expect_reg(8'hF0, 32'h0000_0000);
        wr(`ADDR_CFG, 32'h0000_0001);
        wr(`ADDR_TX_CTRL, 32'h0000_0080);
        // fifth write meets a full fifo and must not move the level
        for (int i = 0; i < 5; i++)
        begin
            q.push_back(9'($urandom));
            wr(`ADDR_DATA_BUF, {23'h0, q[i]});
            expect_reg(`ADDR_TX_STATUS, stat(1'b0, (i < 4) ? i + 1 : 4));
        end
        pulse_in(1'b0, 9'h000);
        expect_reg(`ADDR_TX_STATUS, stat(1'b0, 3));
        check({23'h0, tx_byte_o}, {23'h0, q[1]});
        check({31'h0, tx_byte_valid_o}, 32'h0000_0001);
        wr(`ADDR_TX_CTRL, 32'h0000_0080);
        expect_reg(`ADDR_TX_STATUS, stat(1'b0, 0));
        expect_reg(`ADDR_TX_CTRL, 32'h0000_0000);
        pulse_in(1'b0, 9'h000);
        expect_reg(`ADDR_TX_STATUS, stat(1'b1, 0));
        check(tx_reqs, 0);
        q.delete();
        for (int i = 0; i < 5; i++)
        begin
            q.push_back(9'($urandom));
            pulse_in(1'b1, q[i]);
            expect_reg(`ADDR_RX_STATUS, stat(i == 4, (i < 4) ? i + 1 : 4));
        end
        expect_reg(`ADDR_DATA_BUF, {23'h0, q[0]});
        expect_reg(`ADDR_RX_STATUS, stat(1'b0, 3));
        for (int i = 1; i < 4; i++)
            expect_reg(`ADDR_DATA_BUF, {23'h0, q[i]});
        check(rx_reqs, 0);
        wr(`ADDR_DMA_EN, 32'h0000_0002);
        expect_reg(`ADDR_DMA_EN, 32'h0000_0002);
        dma_hold <= 4'hF;
        pulse_in(1'b1, 9'h0A5);
        settle();
        check(rx_reqs, 1);
        expect_reg(`ADDR_DATA_BUF, 32'h0000_00A5);
        pulse_in(1'b1, 9'h15A);
        repeat (20) @(posedge clk_i);
        #1;
        check(rx_reqs, 1);
        expect_reg(`ADDR_DATA_BUF, 32'h0000_015A);
        pulse_in(1'b1, 9'h033);
        settle();
        check(rx_reqs, 2);
        expect_reg(`ADDR_DATA_BUF, 32'h0000_0033);
        wr(`ADDR_DMA_EN, 32'h0000_0001);
        dma_hold <= 4'h0;
        repeat (16) @(posedge clk_i);
        pulse_in(1'b1, 9'h0C3);
        settle();
        check(rx_reqs, 2);
        expect_reg(`ADDR_DATA_BUF, 32'h0000_00C3);
        for (int i = 0; i < 4; i++)
            wr(`ADDR_DATA_BUF, 32'($urandom) & 32'h0000_01FF);
        pulse_in(1'b0, 9'h000);
        settle();
        check(tx_reqs, 1);
        wr(`ADDR_TX_CTRL, 32'h0000_0080);
        wr(`ADDR_IRQ_STATUS, 32'h0000_000F);
        expect_reg(`ADDR_IRQ_STATUS, 32'h0000_0000);
        pulse_in(1'b0, 9'h000);
        expect_reg(`ADDR_IRQ_STATUS, 32'h0000_0002);
        // mask polarity is not assumed: the two settings must give opposite levels
        wr(`ADDR_IRQ_MASK, 32'h0000_000F);
        settle();
        irq_a = irq_o;
        wr(`ADDR_IRQ_MASK, 32'h0000_0000);
        settle();
        check({31'h0, irq_a ^ irq_o}, 32'h0000_0001);
        // unmask again, so that only the cleared status can drop the line
        wr(`ADDR_IRQ_MASK, irq_a ? 32'h0000_000F : 32'h0000_0000);
        wr(`ADDR_IRQ_STATUS, 32'h0000_0002);
        settle();
        check({31'h0, irq_o}, 32'h0000_0000);
        wr(`ADDR_TX_CTRL, 32'h0000_0005);
        expect_reg(`ADDR_TX_CTRL, 32'h0000_0005);
        channel_run_enable_i <= 1'b0;
        expect_reg(`ADDR_TX_CTRL, 32'h0000_0000);
        channel_run_enable_i <= 1'b1;
        idle_run_enable_i <= 1'b1;
        wr(`ADDR_TX_CTRL, 32'h0000_0005);
        idle_mode_i <= 1'b1;
        expect_reg(`ADDR_TX_CTRL, 32'h0000_0005);
        idle_run_enable_i <= 1'b0;
        expect_reg(`ADDR_TX_CTRL, 32'h0000_0000);
        conclude();
    end
endmodule
